// ---- shared/usbs_pkg.sv ----
package usbs_pkg;

   // register byte offsets
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] RXCFG_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;

   // reset values
   localparam logic [16:0] CFG_RST = 17'h0000a;
   localparam logic [2:0] RXCFG_RST = 3'h1;

   // start pulse saturates at this many transmit periods
   localparam logic [4:0] START_MAX = 5'h03;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BURST = 2'b01,
      ST_LISTEN = 2'b11
   } usbs_state_t;

   typedef struct packed {
      logic amp_bypass;
      logic amp_feedback_select;
      logic damp_en;
      logic shift_en;
      logic [4:0] shift_pos;
      logic [4:0] pulse_count;
      logic [2:0] tx_divider_exponent;
   } usbs_cfg_t;

   typedef struct packed {
      logic [15:0] bursts;
      logic [3:0] pad;
      logic qual;
      logic start;
      logic [2:0] stops;
      logic [4:0] idx;
      logic [1:0] state;
   } usbs_status_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } usbs_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } usbs_wb_rsp_t;

   typedef struct packed {
      usbs_cfg_t cfg;
      logic [2:0] stop_limit;
      usbs_cfg_t act;
      logic [2:0] act_limit;
      logic [1:0] ref_s;
      logic ref_prev;
      logic [1:0] trig_s;
      logic trig_prev;
      logic [1:0] zc_s;
      logic zc_prev;
      logic [1:0] thr_s;
      usbs_state_t state;
      logic [6:0] hcnt;
      logic ph;
      logic [4:0] idx;
      logic qual;
      logic [2:0] stops;
      logic [15:0] bursts;
      logic start;
      logic tx;
      logic damp;
      logic stop;
      logic ack;
      logic [31:0] rdat;
   } usbs_regs_t;

   localparam usbs_regs_t REGS_RST = '{cfg: CFG_RST, stop_limit: RXCFG_RST, act: CFG_RST,
                                       act_limit: RXCFG_RST, state: ST_IDLE, default: '0};

endpackage

// ---- logic/usbs_sequencer.sv ----
`timescale 1ns/10ps
// Operation
// (RULE1) only a trigger starts a measurement cycle
// (RULE2) one start pulse follows each accepted trigger
// (RULE3) burst begins with start rising edge
// (RULE4) divider uses powers of two only
// (RULE5) pulse frequency is reference over 2^(exp+1)
// (RULE6) emit programmed pulse count, then stop driving; a programmed count of 0 sends one pulse
// (RULE7) optional phase inversion from programmed pulse
// (RULE8) optional damping replaces the final pulse
// (RULE9) threshold decides which echoes qualify
// (RULE10) stop pulse marks a qualified zero crossing
// (RULE11) feedback select 0 means capacitive feedback
// (RULE12) feedback select 1 means resistive feedback
// (RULE13) bypass bit bypasses and disables amplifier
// (RULE14) host loads settings before triggering
// (RULE15) start width min(pulse count, 3) periods
// (RULE16) host waits after enable before trigger
// (RULE17) host waits after reset before trigger
// (RULE18) triggers during burst ignored, idle after
// (RULE19) configuration changes apply at next cycle
module usbs_sequencer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire usbs_pkg::usbs_wb_req_t wb_req_i,
   output usbs_pkg::usbs_wb_rsp_t wb_rsp_o,
   input wire logic reference_clock_in_i,
   input wire logic trigger_i,
   input wire logic zero_cross_i,
   input wire logic threshold_i,
   output logic start_o,
   output logic tx_o,
   output logic damp_o,
   output logic stop_o,
   output logic amp_feedback_select_o,
   output logic amp_bypass_o
);
   import usbs_pkg::*;

   usbs_regs_t r;
   usbs_regs_t n;

   logic ref_edge;
   logic trig_edge;
   logic zc_edge;
   logic thr_lvl;
   logic [4:0] cnt;
   logic [4:0] start_len;
   logic [6:0] half_m1;
   logic last;
   logic period_end;
   logic accept;

   // a zero pulse count still sends one pulse
   function automatic logic [4:0] count_of(input usbs_cfg_t c);
      count_of = (c.pulse_count == 5'h00) ? 5'h01 : c.pulse_count;
   endfunction

   assign ref_edge = r.ref_s[1] & ~r.ref_prev;
   assign trig_edge = r.trig_s[1] & ~r.trig_prev;
   assign zc_edge = r.zc_s[1] & ~r.zc_prev;
   assign thr_lvl = r.thr_s[1];
   assign cnt = count_of(r.act);
   assign start_len = (cnt > START_MAX) ? START_MAX : cnt;
   assign half_m1 = 7'((8'h01 << r.act.tx_divider_exponent) - 8'h01); // RULE4
   assign last = (r.idx == cnt - 5'h01);
   assign period_end = ref_edge & r.ph & (r.hcnt == half_m1);
   assign accept = trig_edge & (r.state != ST_BURST); // RULE1 RULE18

   always_comb begin
      logic [31:0] merged;
      logic [31:0] cur;
      usbs_status_t st;
      merged = '0;
      cur = '0;
      st = '0;
      n = r;

      // pin synchronisers, first stage feeds only the second
      n.ref_s = {r.ref_s[0], reference_clock_in_i};
      n.ref_prev = r.ref_s[1];
      n.trig_s = {r.trig_s[0], trigger_i};
      n.trig_prev = r.trig_s[1];
      n.zc_s = {r.zc_s[0], zero_cross_i};
      n.zc_prev = r.zc_s[1];
      n.thr_s = {r.thr_s[0], threshold_i};
      n.stop = 1'b0;

      // bus slave: ack one cycle after request, write at ack edge
      st.bursts = r.bursts;
      st.qual = r.qual;
      st.start = r.start;
      st.stops = r.stops;
      st.idx = r.idx;
      st.state = r.state;
      case (wb_req_i.adr)
         CFG_OFS: cur = {15'h0000, r.cfg};
         RXCFG_OFS: cur = {29'h00000000, r.stop_limit};
         STATUS_OFS: cur = st;
         default: cur = '0;
      endcase
      merged = cur;
      for (int b = 0; b < 4; b++) begin
         if (wb_req_i.sel[b]) begin
            merged[8*b +: 8] = wb_req_i.dat[8*b +: 8];
         end
      end
      n.ack = wb_req_i.cyc & wb_req_i.stb & ~r.ack;
      if (n.ack) begin
         n.rdat = cur;
      end
      if (wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && r.ack) begin
         if (wb_req_i.adr == CFG_OFS) begin
            n.cfg = merged[16:0];
         end
         if (wb_req_i.adr == RXCFG_OFS) begin
            n.stop_limit = merged[2:0];
         end
      end

      // settings follow software only between measurements
      if (r.state == ST_IDLE) begin // RULE19
         n.act = r.cfg;
         n.act_limit = r.stop_limit;
      end

      case (r.state)
         ST_IDLE: begin
            n.qual = 1'b0;
         end
         ST_BURST: begin
            if (ref_edge) begin
               if (r.hcnt == half_m1) begin // RULE5
                  n.hcnt = 7'h00;
                  n.ph = ~r.ph;
                  if (r.ph) begin
                     n.idx = r.idx + 5'h01;
                     if (last) begin // RULE6
                        n.state = ST_LISTEN;
                        n.stops = 3'h0;
                        n.qual = 1'b0;
                     end
                  end
               end else begin
                  n.hcnt = r.hcnt + 7'h01;
               end
            end
         end
         ST_LISTEN: begin
            if (r.act_limit == 3'h0 || r.stops >= r.act_limit) begin
               n.state = ST_IDLE;
            end else if (zc_edge && r.qual) begin // RULE10
               n.stop = 1'b1;
               n.qual = 1'b0;
               n.stops = r.stops + 3'h1;
               if (r.stops + 3'h1 >= r.act_limit) begin // RULE18
                  n.state = ST_IDLE;
               end
            end else if (thr_lvl) begin // RULE9
               n.qual = 1'b1;
            end
         end
         default: begin
            n.state = ST_IDLE;
         end
      endcase

      if (accept) begin // RULE1
         n.act = r.cfg;
         n.act_limit = r.stop_limit;
         n.state = ST_BURST;
         n.hcnt = 7'h00;
         n.ph = 1'b0;
         n.idx = 5'h00;
         n.qual = 1'b0;
         n.stop = 1'b0;
         n.bursts = r.bursts + 16'h0001;
      end

      // output levels registered alongside the state they describe
      n.start = 1'b0;
      n.tx = 1'b0;
      n.damp = 1'b0;
      if (n.state == ST_BURST) begin
         n.start = n.idx < ((count_of(n.act) > START_MAX) ? START_MAX : count_of(n.act)); // RULE2 RULE15
         if (n.act.damp_en && n.idx == count_of(n.act) - 5'h01) begin // RULE8
            n.damp = ~n.ph;
         end else if (n.act.shift_en && n.idx >= n.act.shift_pos) begin // RULE7
            n.tx = n.ph;
         end else begin // RULE3
            n.tx = ~n.ph;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= REGS_RST;
      end else begin
         r <= n;
      end
   end

   assign wb_rsp_o = '{ack: r.ack, dat: r.rdat};
   assign start_o = r.start;
   assign tx_o = r.tx;
   assign damp_o = r.damp;
   assign stop_o = r.stop;
   assign amp_feedback_select_o = r.act.amp_feedback_select; // RULE11 RULE12
   assign amp_bypass_o = r.act.amp_bypass; // RULE13

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_accept;
      trig_edge && r.state != ST_BURST;
   endsequence

   sequence s_period_end;
      r.state == ST_BURST && period_end;
   endsequence

   sequence s_last_end;
      s_period_end ##0 last;
   endsequence

   a_trigger_accept: assert property (s_accept |=> r.state == ST_BURST && start_o && r.idx == 5'h00) // RULE1
      else $error("accepted trigger did not open a burst");

   a_start_origin: assert property ($rose(start_o) |-> $past(trig_edge) && $past(r.state) != ST_BURST) // RULE2
      else $error("start pulse without a trigger");

   a_start_align: assert property ($rose(start_o) |-> r.hcnt == 7'h00 && !r.ph &&
      (tx_o || damp_o || (r.act.shift_en && r.act.shift_pos == 5'h00))) // RULE3
      else $error("burst not aligned to start edge");

   a_half_toggle: assert property ((r.state == ST_BURST && ref_edge && r.hcnt == half_m1 && !(r.ph && last))
      |=> r.ph != $past(r.ph) && r.hcnt == 7'h00) // RULE4
      else $error("half period not a power of two");

   a_hcnt_range: assert property (r.state == ST_BURST |-> r.hcnt <= half_m1) // RULE5
      else $error("divider count beyond half period");

   a_burst_end: assert property (s_last_end |=> r.state == ST_LISTEN && !tx_o && !damp_o && !start_o) // RULE6
      else $error("burst did not stop after last pulse");

   a_idx_range: assert property (r.state == ST_BURST |-> r.idx < cnt) // RULE6
      else $error("pulse index beyond count");

   a_shift_phase: assert property ((r.state == ST_BURST && r.act.shift_en && r.idx >= r.act.shift_pos &&
      !(r.act.damp_en && last)) |-> tx_o == r.ph) // RULE7
      else $error("phase inversion missing");

   a_damp_last: assert property ((r.state == ST_BURST && r.act.damp_en && last) |-> !tx_o && damp_o == !r.ph) // RULE8
      else $error("damping pulse missing");

   a_qual_set: assert property ((r.state == ST_LISTEN && thr_lvl && !trig_edge && !(zc_edge && r.qual) &&
      r.act_limit != 3'h0 && r.stops < r.act_limit) |=> r.qual) // RULE9
      else $error("threshold did not qualify echo");

   a_stop_cause: assert property (stop_o |-> $past(r.qual) && $past(zc_edge) && $past(r.state) == ST_LISTEN) // RULE10
      else $error("stop pulse without qualified crossing");

   a_amp_feedback: assert property ((r.state == ST_IDLE && !trig_edge) |=>
      amp_feedback_select_o == $past(r.cfg.amp_feedback_select)) // RULE12
      else $error("feedback select not applied");

   a_amp_bypass: assert property ((r.state == ST_IDLE && !trig_edge) |=>
      amp_bypass_o == $past(r.cfg.amp_bypass)) // RULE13
      else $error("bypass not applied");

   a_start_width: assert property (start_o |-> r.state == ST_BURST && r.idx < start_len) // RULE15
      else $error("start pulse too wide");

   a_busy_ignore: assert property ((r.state == ST_BURST && trig_edge) |=> $stable(r.bursts)) // RULE18
      else $error("trigger accepted during burst");

   a_cfg_frozen: assert property (r.state == ST_BURST |=> $stable(r.act)) // RULE19
      else $error("settings changed inside a burst");

endmodule

// ---- tb/usbs_echo_model.sv ----
`timescale 1ns/10ps
module usbs_echo_model (
   input wire logic clk_i,
   input wire logic go_i,
   output logic ref_o,
   output logic thr_o,
   output logic zc_o
);
   logic [2:0] rc = 3'h0;
   logic [5:0] e = 6'h00;
   // free-running reference, eight system cycles a period
   assign ref_o = rc[2];
   // a bare crossing first, then threshold, then a qualified crossing
   assign zc_o = (e >= 6'h02 && e < 6'h06) || (e >= 6'h1e && e < 6'h22);
   assign thr_o = e >= 6'h0f && e < 6'h15;
   always_ff @(posedge clk_i) begin
      rc <= rc + 3'h1;
      if (go_i) begin
         e <= 6'h01;
      end else if (e != 6'h00) begin
         e <= e + 6'h01;
      end
   end
endmodule

// ---- tb/usbs_sequencer_tb.sv ----
`timescale 1ns/10ps
module usbs_sequencer_tb;
   import usbs_pkg::*;
   typedef struct {string name; logic [31:0] val; logic [31:0] mask;} usbs_note_t;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   usbs_wb_req_t req = '0;
   usbs_wb_rsp_t rsp;
   logic trig = 1'b0;
   logic go = 1'b0;
   logic refc, thr, zc, start, tx, damp, stop, fb, bp;
   logic ptx = 1'b0, pst = 1'b0, pdm = 1'b0, tas = 1'b0;
   logic [7:0] txr = 8'h00, dr = 8'h00;
   logic [1:0] pamp = 2'h0;
   usbs_note_t q[$];
   integer failures = 0;
   integer checks = 0;
   integer seed = 82;
   integer cyc_n = 0;
   integer sw = 0;
   usbs_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
      .reference_clock_in_i(refc), .trigger_i(trig), .zero_cross_i(zc), .threshold_i(thr),
      .start_o(start), .tx_o(tx), .damp_o(damp), .stop_o(stop), .amp_feedback_select_o(fb),
      .amp_bypass_o(bp));
   usbs_echo_model echo (.clk_i(clk_i), .go_i(go), .ref_o(refc), .thr_o(thr), .zc_o(zc));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   task note(input string n, input logic [31:0] v, input logic [31:0] m);
      q.push_back('{n, v, m});
   endtask
   task take(input logic [31:0] v);
      usbs_note_t x;
      checks++;
      if (q.size() == 0) begin
         failures++;
         $display("[ERR] unexpected exp none seen %h", v);
      end else begin
         x = q.pop_front();
         if ((v & x.mask) !== x.val) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", x.name, x.val, v & x.mask);
         end
      end
   endtask
   task wrap_up;
      if (q.size() != 0) begin
         failures++;
         $display("[ERR] pending exp 0 seen %0d", q.size());
      end
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer n;
      n = 0;
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.ack !== 1'b1 && n < 40);
      if (rsp.ack !== 1'b1) begin
         failures++;
         $display("[ERR] ack exp 1 seen %b", rsp.ack);
      end
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
   endtask
   task pulse_trigger;
      // raise the trigger together with a reference rising edge so the first period is whole
      do begin
         @(posedge clk_i);
      end while (echo.rc !== 3'h3);
      trig <= 1'b1;
      repeat (2) @(posedge clk_i);
      trig <= 1'b0;
   endtask
   // watches every result and takes the oldest note for it
   always @(posedge clk_i) begin
      cyc_n++;
      if (cyc_n > 20000) begin
         failures++;
         wrap_up();
      end
      if (rst_i === 1'b0) begin
         if (rsp.ack === 1'b1 && req.we === 1'b0) take(rsp.dat);
         if (start === 1'b1 && pst !== 1'b1) begin
            tas = tx;
            txr = 8'h00;
            dr = 8'h00;
         end
         if (start === 1'b1) begin
            sw++;
         end else if (sw > 0) begin
            take(sw);
            sw = 0;
         end
         if (tx === 1'b1 && ptx !== 1'b1) txr++;
         if (damp === 1'b1 && pdm !== 1'b1) dr++;
         if (stop === 1'b1) take({15'h0, tas, dr, txr});
         if ({bp, fb} !== pamp) begin
            take({30'h0, bp, fb});
            pamp = {bp, fb};
         end
      end
      ptx = tx;
      pst = start;
      pdm = damp;
   end
   initial begin
      integer i;
      logic [31:0] r;
      logic [2:0] ex;
      logic [4:0] cnt;
      logic dm, sh;
      logic [1:0] amp;
      logic [16:0] cfg;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (800) @(posedge clk_i);
      note("cfg", {15'h0, CFG_RST}, 32'hffffffff);
      wb(1'b0, CFG_OFS, 32'h0);
      note("rxcfg", {29'h0, RXCFG_RST}, 32'hffffffff);
      wb(1'b0, RXCFG_OFS, 32'h0);
      note("unmapped", 32'h0, 32'hffffffff);
      wb(1'b1, 8'h0c, 32'hffffffff);
      wb(1'b0, 8'h0c, 32'h0);
      for (i = 1; i < 6; i++) begin
         r = $random(seed);
         ex = {2'h0, r[0]};
         cnt = {3'h0, r[2:1]} + 5'h01;
         if (i == 2) cnt[1] = 1'b1;
         dm = r[3];
         sh = r[4];
         amp = i[1:0];
         cfg = {amp, dm, sh, 5'h00, cnt, ex};
         note("amp", {30'h0, amp}, 32'h3);
         wb(1'b1, CFG_OFS, {15'h0, cfg});
         repeat (4) @(posedge clk_i);
         note("start width", (cnt > START_MAX ? START_MAX : cnt) * (16 << ex), '1);
         note("burst", {15'h0, ~(sh | (dm & (cnt == 5'h01))), 7'h0, dm, 3'h0, cnt - {4'h0, dm}}, '1);
         pulse_trigger();
         if (i == 2) begin
            wb(1'b1, CFG_OFS, {15'h0, cfg ^ 17'h000f8});
            pulse_trigger();
         end
         repeat (cnt * (16 << ex) + 20) @(posedge clk_i);
         go <= 1'b1;
         @(posedge clk_i);
         go <= 1'b0;
         repeat (60) @(posedge clk_i);
      end
      note("bursts", 32'h00050000, 32'hffff0000);
      wb(1'b0, STATUS_OFS, 32'h0);
      @(posedge clk_i);
      wrap_up();
   end
endmodule
